// *** verilog/uer_map.svh ***
`ifndef UER_MAP_SVH
`define UER_MAP_SVH
`define UER_STATUS_ADDR 8'h14
`define UER_STATUS_RESET 8'h00
`define UER_BIT_SETUP 0
`define UER_BIT_OUT 1
`define UER_BIT_IN 2
`define UER_BIT_TOGGLE 3
`define UER_COUNT_LSB 4
`define UER_FIFO_BASE 8'h70
`define UER_FIFO_DEPTH 8
`define UER_IRQ_MASK_BIT 3
`endif

// *** verilog/uer_pkg.sv ***
package uer_pkg;
   typedef enum logic [1:0] {uer_tok_out, uer_tok_in, uer_tok_setup} uer_token_type;
   typedef enum {uer_idle, uer_data, uer_commit, uer_irq} uer_state_type;
endpackage : uer_pkg

// *** verilog/uer_fifo_mem.sv ***
`include "uer_map.svh"
module uer_fifo_mem #(
   parameter int DEPTH = `UER_FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // write port
   input wire logic i_we,
   input wire logic [2:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // read port
   input wire logic [2:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [DEPTH];
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = mem[i_raddr];
   end
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= next_rdata;
      end
   end
endmodule : uer_fifo_mem

// *** verilog/uer_ep0_rx.sv ***
`include "uer_map.svh"
module uer_ep0_rx (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // serial engine side
   input wire logic i_tok_valid,
   input wire logic [1:0] i_tok_type,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   input wire logic i_pkt_end,
   input wire logic i_pkt_ok,
   input wire logic i_pkt_toggle,
   // endpoint controls
   input wire logic i_halt_ctl,
   input wire logic i_accept_out_ctl,
   input wire logic i_status_out_ctl,
   input wire logic i_ep0_irq_mask_bit,
   // firmware io port
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   // firmware fifo port
   input wire logic i_fw_fifo_wr,
   input wire logic [2:0] i_fw_fifo_addr,
   input wire logic [7:0] i_fw_fifo_wdata,
   input wire logic [2:0] i_fifo_raddr,
   output logic [7:0] o_fifo_rdata,
   // status
   output logic o_fw_fifo_blocked,
   output logic o_ep0_irq
);
   uer_pkg::uer_state_type state, next_state;
   logic [7:0] status, next_status;
   logic last_setup, next_last_setup;
   logic store, next_store, upd, next_upd;
   logic [3:0] cnt, next_cnt;
   logic tog, next_tog;
   logic [7:0] rdata, next_rdata;
   logic next_irq;
   logic sie_we;
   logic [2:0] sie_addr;
   logic mem_we;
   logic [2:0] mem_addr;
   logic [7:0] mem_wdata;

   function automatic logic hit(input logic [7:0] a);
      hit = (a == `UER_STATUS_ADDR);
   endfunction : hit

   assign sie_we = (state == uer_pkg::uer_data) && i_byte_valid && store && (cnt < 4'd8);
   assign sie_addr = cnt[2:0];
   // firmware writes gated while setup flag is set
   assign mem_we = sie_we || (i_fw_fifo_wr && !status[`UER_BIT_SETUP]);
   assign mem_addr = sie_we ? sie_addr : i_fw_fifo_addr;
   assign mem_wdata = sie_we ? i_byte : i_fw_fifo_wdata;

   uer_fifo_mem #(.DEPTH(`UER_FIFO_DEPTH)) u_mem (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_we(mem_we),
      .i_waddr(mem_addr),
      .i_wdata(mem_wdata),
      .i_raddr(i_fifo_raddr),
      .o_rdata(o_fifo_rdata)
   );

   always_comb begin
      next_state = state;
      next_status = status;
      next_last_setup = last_setup;
      next_store = store;
      next_upd = upd;
      next_cnt = cnt;
      next_tog = tog;
      next_irq = 1'b0;
      next_rdata = hit(i_io_addr) && i_io_rd ? status : 8'h00;
      if (i_io_wr && hit(i_io_addr)) begin
         // keep toggle bit; keep setup flag while setup data arrives
         next_status = {4'h0, status[`UER_BIT_TOGGLE], 3'b000};
         if (state == uer_pkg::uer_data && last_setup) begin
            next_status[`UER_BIT_SETUP] = status[`UER_BIT_SETUP];
         end
      end
      case (state)
         uer_pkg::uer_idle: begin
            if (i_tok_valid) begin
               next_status[`UER_BIT_OUT] = (i_tok_type == uer_pkg::uer_tok_out);
               next_status[`UER_BIT_IN] = (i_tok_type == uer_pkg::uer_tok_in);
               if (i_tok_type == uer_pkg::uer_tok_setup) begin
                  next_status[`UER_BIT_SETUP] = 1'b1;
               end
               next_last_setup = (i_tok_type == uer_pkg::uer_tok_setup);
               next_cnt = 4'h0;
               if (i_tok_type == uer_pkg::uer_tok_setup) begin
                  next_store = 1'b1;
                  next_upd = 1'b1;
                  next_state = uer_pkg::uer_data;
               end else if (i_tok_type == uer_pkg::uer_tok_out) begin
                  next_store = i_accept_out_ctl && !i_halt_ctl && !i_status_out_ctl;
                  next_upd = !i_halt_ctl && (i_accept_out_ctl || i_status_out_ctl);
                  next_state = uer_pkg::uer_data;
               end
            end
         end
         uer_pkg::uer_data: begin
            if (i_byte_valid && cnt != 4'hf) begin
               next_cnt = cnt + 4'h1;
            end
            if (i_pkt_end) begin
               next_tog = i_pkt_toggle;
               next_state = (i_pkt_ok && upd) ? uer_pkg::uer_commit : uer_pkg::uer_idle;
            end
         end
         uer_pkg::uer_commit: begin
            next_status[7:`UER_COUNT_LSB] = cnt;
            next_status[`UER_BIT_TOGGLE] = tog;
            next_state = uer_pkg::uer_irq;
         end
         default: begin
            next_irq = i_ep0_irq_mask_bit;
            next_state = uer_pkg::uer_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= uer_pkg::uer_idle;
         status <= `UER_STATUS_RESET;
         last_setup <= 1'b0;
         store <= 1'b0;
         upd <= 1'b0;
         cnt <= 4'h0;
         tog <= 1'b0;
         o_io_rdata <= 8'h00;
         o_fw_fifo_blocked <= 1'b0;
         o_ep0_irq <= 1'b0;
      end else begin
         state <= next_state;
         status <= next_status;
         last_setup <= next_last_setup;
         store <= next_store;
         upd <= next_upd;
         cnt <= next_cnt;
         tog <= next_tog;
         o_io_rdata <= next_rdata;
         o_fw_fifo_blocked <= next_status[`UER_BIT_SETUP];
         o_ep0_irq <= next_irq;
      end
   end

   property p_irq_after_commit;
      @(posedge i_clk) disable iff (!i_resetn)
      o_ep0_irq |-> $past(state == uer_pkg::uer_commit, 2);
   endproperty
   a_irq_after_commit: assert property (p_irq_after_commit) else $error("irq without commit");
   property p_write_clears;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_io_wr && hit(i_io_addr) && state == uer_pkg::uer_idle && !i_tok_valid)
         |=> status == {4'h0, $past(status[3]), 3'b000};
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("write clear wrong");
   property p_setup_sets;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_idle && i_tok_valid && i_tok_type == uer_pkg::uer_tok_setup)
         |=> status[0] && status[2:1] == 2'b00;
   endproperty
   a_setup_sets: assert property (p_setup_sets) else $error("setup flag not set");
   property p_setup_held;
      @(posedge i_clk) disable iff (!i_resetn)
      (status[0] && state == uer_pkg::uer_data && last_setup) |=> status[0];
   endproperty
   a_setup_held: assert property (p_setup_held) else $error("setup flag lost");
   property p_fw_block;
      @(posedge i_clk) disable iff (!i_resetn)
      (status[0] && i_fw_fifo_wr && !(state == uer_pkg::uer_data && i_byte_valid && store))
         |-> !mem_we;
   endproperty
   a_fw_block: assert property (p_fw_block) else $error("fifo write not blocked");
   property p_out_flag;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_idle && i_tok_valid && i_tok_type == uer_pkg::uer_tok_out
         && !(i_io_wr && hit(i_io_addr))) |=> status[2:1] == 2'b01;
   endproperty
   a_out_flag: assert property (p_out_flag) else $error("out flag wrong");
   property p_toggle_ro;
      @(posedge i_clk) disable iff (!i_resetn)
      (state != uer_pkg::uer_commit) |=> status[3] == $past(status[3]);
   endproperty
   a_toggle_ro: assert property (p_toggle_ro) else $error("toggle changed");
   property p_count;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_commit) |=> status[7:4] == $past(cnt);
   endproperty
   a_count: assert property (p_count) else $error("count wrong");
   property p_out_store;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_idle && i_tok_valid && i_tok_type == uer_pkg::uer_tok_out
         && i_halt_ctl) |=> !store && !upd;
   endproperty
   a_out_store: assert property (p_out_store) else $error("halted out stored");
   property p_in_flag;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_idle && i_tok_valid && i_tok_type == uer_pkg::uer_tok_in)
         |=> status[2:1] == 2'b10;
   endproperty
   a_in_flag: assert property (p_in_flag) else $error("in flag wrong");
   property p_setup_stays;
      @(posedge i_clk) disable iff (!i_resetn)
      (status[0] && !(i_io_wr && hit(i_io_addr))) |=> status[0];
   endproperty
   a_setup_stays: assert property (p_setup_stays) else $error("setup flag dropped");
   property p_nak_quiet;
      @(posedge i_clk) disable iff (!i_resetn)
      (state == uer_pkg::uer_data && i_pkt_end && !(i_pkt_ok && upd))
         |=> (!o_ep0_irq) [*3];
   endproperty
   a_nak_quiet: assert property (p_nak_quiet) else $error("irq on refused packet");
   property p_irq_mask;
      @(posedge i_clk) disable iff (!i_resetn)
      o_ep0_irq |-> $past(i_ep0_irq_mask_bit);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
   c_setup: cover property (@(posedge i_clk) state == uer_pkg::uer_commit && last_setup);
   c_out: cover property (@(posedge i_clk) state == uer_pkg::uer_commit && !last_setup);
   c_irq: cover property (@(posedge i_clk) o_ep0_irq);
   c_block: cover property (@(posedge i_clk) i_fw_fifo_wr && status[0]);
endmodule : uer_ep0_rx

// *** tb/uer_host_model.sv ***
module uer_host_model (
   // clock
   input wire logic i_clk,
   // serial engine side
   output logic o_tok_valid,
   output logic [1:0] o_tok_type,
   output logic o_byte_valid,
   output logic [7:0] o_byte,
   output logic o_pkt_end,
   output logic o_pkt_ok,
   output logic o_pkt_toggle
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {o_tok_valid, o_tok_type, o_byte_valid, o_byte} = 12'h0;
      {o_pkt_end, o_pkt_ok, o_pkt_toggle} = 3'h0;
   end
   // one token, then n data bytes unless the token is in
   task automatic send(input uer_pkg::uer_token_type tok, input int n,
                       input logic [7:0] b0, input logic tgl);
      @(posedge i_clk);
      o_tok_valid <= 1'b1;
      o_tok_type <= tok;
      @(posedge i_clk);
      o_tok_valid <= 1'b0;
      if (tok != uer_pkg::uer_tok_in) begin
         for (int k = 0; k < n; k++) begin
            o_byte_valid <= 1'b1;
            o_byte <= b0 + 8'(k);
            @(posedge i_clk);
         end
         o_byte_valid <= 1'b0;
         o_byte <= ~o_byte;
         o_pkt_end <= 1'b1;
         o_pkt_ok <= 1'b1;
         o_pkt_toggle <= tgl;
         @(posedge i_clk);
         o_pkt_end <= 1'b0;
         o_pkt_ok <= 1'b0;
         o_pkt_toggle <= ~tgl;
      end
   endtask : send
endmodule : uer_host_model

// *** tb/test_uer_ep0_rx.sv ***
module test_uer_ep0_rx;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, tv, bv, pe, pk, pt, halt = 1'b0, acc = 1'b0, sto = 1'b0;
   logic msk = 1'b1, wr = 1'b0, rd = 1'b0, fw = 1'b0, blk, irq, seen;
   logic [1:0] tt;
   logic [2:0] fa = 3'h0, ra = 3'h0;
   logic [7:0] by, ad = 8'h0, wd = 8'h0, fd = 8'h0, rdat, fdat;
   int err_total = 0, comparisons = 0, cyc = 0;
   always #50 clk = ~clk;
   uer_host_model i_host (.i_clk(clk), .o_tok_valid(tv), .o_tok_type(tt), .o_byte_valid(bv),
      .o_byte(by), .o_pkt_end(pe), .o_pkt_ok(pk), .o_pkt_toggle(pt));
   uer_ep0_rx i_dut (.i_clk(clk), .i_resetn(rstn), .i_tok_valid(tv), .i_tok_type(tt),
      .i_byte_valid(bv), .i_byte(by), .i_pkt_end(pe), .i_pkt_ok(pk), .i_pkt_toggle(pt),
      .i_halt_ctl(halt), .i_accept_out_ctl(acc), .i_status_out_ctl(sto),
      .i_ep0_irq_mask_bit(msk), .i_io_wr(wr), .i_io_rd(rd), .i_io_addr(ad), .i_io_wdata(wd),
      .o_io_rdata(rdat), .i_fw_fifo_wr(fw), .i_fw_fifo_addr(fa), .i_fw_fifo_wdata(fd),
      .i_fifo_raddr(ra), .o_fifo_rdata(fdat), .o_fw_fifo_blocked(blk), .o_ep0_irq(irq));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test;
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic io_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) {rd, ad} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) chk("status", e, rdat);
   endtask : io_chk
   task automatic io_wr;
      @(posedge clk) {wr, ad, wd} <= {1'b1, 8'h14, 8'hff};
      @(posedge clk) wr <= 1'b0;
   endtask : io_wr
   task automatic fw_wr(input logic [7:0] d);
      @(posedge clk) {fw, fa, fd} <= {1'b1, 3'h0, d};
      @(posedge clk) fw <= 1'b0;
   endtask : fw_wr
   task automatic fifo_chk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) ra <= a;
      repeat (2) @(posedge clk);
      @(negedge clk) chk("fifo", e, fdat);
   endtask : fifo_chk
   task automatic irq_chk(input logic e);
      seen = 1'b0;
      repeat (6) @(negedge clk) seen = seen | irq;
      chk("irq", {7'h0, e}, {7'h0, seen});
   endtask : irq_chk
   task automatic t_setup;
      i_host.send(uer_pkg::uer_tok_setup, 3, 8'h10, 1'b1);
      irq_chk(1'b1);
      io_chk(8'h14, 8'h39);
      chk("blocked", 8'h1, {7'h0, blk});
      fw_wr(8'haa);
      fifo_chk(3'h0, 8'h10);
      io_chk(8'h14, 8'h39);
      io_wr;
      io_chk(8'h14, 8'h08);
      chk("blocked", 8'h0, {7'h0, blk});
      fw_wr(8'haa);
      fifo_chk(3'h0, 8'haa);
   endtask : t_setup
   task automatic t_outs;
      @(posedge clk) acc <= 1'b1;
      i_host.send(uer_pkg::uer_tok_out, 4, 8'h40, 1'b0);
      irq_chk(1'b1);
      io_chk(8'h14, 8'h42);
      fifo_chk(3'h1, 8'h41);
      @(posedge clk) {acc, sto} <= 2'b01;
      i_host.send(uer_pkg::uer_tok_out, 2, 8'h50, 1'b1);
      irq_chk(1'b1);
      io_chk(8'h14, 8'h2a);
      fifo_chk(3'h0, 8'h40);
      @(posedge clk) {halt, acc, sto} <= 3'b110;
      i_host.send(uer_pkg::uer_tok_out, 5, 8'h60, 1'b0);
      irq_chk(1'b0);
      io_chk(8'h14, 8'h2a);
      fifo_chk(3'h0, 8'h40);
      @(posedge clk) {halt, acc} <= 2'b00;
      i_host.send(uer_pkg::uer_tok_out, 3, 8'h70, 1'b0);
      irq_chk(1'b0);
      io_chk(8'h14, 8'h2a);
      fifo_chk(3'h0, 8'h40);
   endtask : t_outs
   task automatic t_in;
      i_host.send(uer_pkg::uer_tok_in, 0, 8'h0, 1'b0);
      io_chk(8'h14, 8'h2c);
   endtask : t_in
   task automatic t_guard;
      @(posedge clk) msk <= 1'b0;
      fork
         i_host.send(uer_pkg::uer_tok_setup, 10, 8'h20, 1'b0);
         begin
            repeat (3) @(posedge clk);
            io_wr;
         end
      join
      irq_chk(1'b0);
      io_chk(8'h14, 8'ha1);
      fifo_chk(3'h7, 8'h27);
      fifo_chk(3'h0, 8'h20);
   endtask : t_guard
   task automatic t_reset;
      @(posedge clk) rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      io_chk(8'h14, 8'h00);
      chk("blocked", 8'h0, {7'h0, blk});
   endtask : t_reset
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      io_chk(8'h14, 8'h00);
      io_chk(8'h15, 8'h00);
      t_setup;
      t_outs;
      t_in;
      t_guard;
      t_reset;
      stop_test;
   end
endmodule : test_uer_ep0_rx
